// *** tpbm_defines.svh ***
// Purpose: Constants of the two-port block memory with its register slave
// Assumes: Included by its bare name wherever a constant is needed
// Notes:   Field macros are bit ranges, used as reg[`FIELD]
`ifndef TPBM_DEFINES_SVH
`define TPBM_DEFINES_SVH

// Register byte offsets on the AXI4-Lite slave
`define TPBM_AXI_AW          4
`define TPBM_OFS_CFG         4'h0
`define TPBM_OFS_STAT        4'h4

// Configuration register fields
`define TPBM_CFG_WSEL        1:0
`define TPBM_CFG_RW          3:2
`define TPBM_CFG_WFALL       4
`define TPBM_CFG_RFALL       5
`define TPBM_CFG_WEN_HI      6
`define TPBM_CFG_REN_HI      7
`define TPBM_CFG_PIPE        8
`define TPBM_CFG_RST         32'h0000_0005
`define TPBM_CFG_MASK        32'h0000_01ff

// Status register fields
`define TPBM_STAT_WSEL_BAD   0
`define TPBM_STAT_RW_BAD     1
`define TPBM_STAT_WCNT       15:8
`define TPBM_STAT_RCNT       23:16

// Width select codes
`define TPBM_WIDTH_9         2'h1
`define TPBM_WIDTH_18        2'h2

// AXI responses
`define TPBM_RESP_OKAY       2'h0
`define TPBM_RESP_SLVERR     2'h2

// Memory geometry: two banks of 256 words by 9 bits
`define TPBM_BANKS           2
`define TPBM_ROW_W           8
`define TPBM_ROWS            256
`define TPBM_HALF_W          9
`define TPBM_DATA_W          18
`define TPBM_ADDR_W          9
`define TPBM_CNT_W           8

// Input synchroniser vector layout
`define TPBM_SY_W            40
`define TPBM_SY_WCLK         39
`define TPBM_SY_RCLK         38
`define TPBM_SY_WEN          37
`define TPBM_SY_REN          36
`define TPBM_SY_WR_ADDR      35:27
`define TPBM_SY_RD_ADDR      26:18
`define TPBM_SY_WDATA        17:0

`endif

// *** tpbm_pkg.sv ***
// Purpose: Types shared by the two-port block memory files
// Assumes: Constants come from tpbm_defines.svh
// Notes:   Holds types only
package tpbm_pkg;

   typedef enum logic [0:0]
   {
      TPBM_WR_COLLECT = 1'b0,
      TPBM_WR_RESP    = 1'b1
   } tpbm_wr_state_t;

   typedef enum logic [0:0]
   {
      TPBM_RD_IDLE    = 1'b0,
      TPBM_RD_RESP    = 1'b1
   } tpbm_rd_state_t;

endpackage : tpbm_pkg

// *** tpbm_mem_if.sv ***
// Purpose: Carrier between the port control and the storage array
// Assumes: One clock, owned by the storage module
// Notes:   Bank 0 holds the low half of an 18-bit word
`timescale 1ns/10ps
`include "tpbm_defines.svh"

interface tpbm_mem_if;
   logic [`TPBM_BANKS-1:0]   we;
   logic [`TPBM_ROW_W-1:0]   wrow;
   logic [`TPBM_DATA_W-1:0]  wdata;
   logic                     re;
   logic [`TPBM_ROW_W-1:0]   rrow;
   logic [`TPBM_DATA_W-1:0]  rdata;

   modport ctrl (output we, output wrow, output wdata, output re,
                 output rrow, input rdata);
   modport mem  (input we, input wrow, input wdata, input re,
                 input rrow, output rdata);
endinterface : tpbm_mem_if

// *** tpbm_store.sv ***
// Purpose: Storage array of two 256 by 9 banks with a registered read
// Assumes: Write and read strobes are single-cycle pulses
// Notes:   The array itself is never reset, only the read register
`timescale 1ns/10ps
`include "tpbm_defines.svh"

module tpbm_store
   import tpbm_pkg::*;
(
   input  wire logic   aclk,
   input  wire logic   aresetn,
   tpbm_mem_if.mem     port
);

   logic [`TPBM_DATA_W-1:0] rdata_ff;
   logic [`TPBM_DATA_W-1:0] nxt_rdata;

   genvar b;
   generate
      for (b = 0; b < `TPBM_BANKS; b++)
      begin : g_bank
         logic [`TPBM_HALF_W-1:0] array [`TPBM_ROWS];

         // No reset here: contents survive reset
         always_ff @(posedge aclk)
         begin
            if (port.we[b])
               array[port.wrow] <= port.wdata[b*`TPBM_HALF_W +: `TPBM_HALF_W];
         end

         always_comb
         begin
            nxt_rdata[b*`TPBM_HALF_W +: `TPBM_HALF_W] =
               port.re ? array[port.rrow]
                       : rdata_ff[b*`TPBM_HALF_W +: `TPBM_HALF_W];
         end
      end
   endgenerate

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rdata_ff <= '0;
      else
         rdata_ff <= nxt_rdata;
   end

   assign port.rdata = rdata_ff;

endmodule : tpbm_store

// *** tpbm_two_port_ram.sv ***
// Purpose: Two-port block memory, 512x9 or 256x18, with AXI4-Lite setup
// Assumes: Port clocks are slow fabric signals sampled on aclk
// Notes:   Port inputs pass three flops; clock edges are found after that
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "tpbm_defines.svh"

module tpbm_two_port_ram
   import tpbm_pkg::*;
(
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [`TPBM_AXI_AW-1:0]  awaddr,
   input  wire logic                     awvalid,
   output logic                          awready,
   input  wire logic [31:0]              wdata,
   input  wire logic [3:0]               wstrb,
   input  wire logic                     wvalid,
   output logic                          wready,
   output logic [1:0]                    bresp,
   output logic                          bvalid,
   input  wire logic                     bready,
   input  wire logic [`TPBM_AXI_AW-1:0]  araddr,
   input  wire logic                     arvalid,
   output logic                          arready,
   output logic [31:0]                   rdata,
   output logic [1:0]                    rresp,
   output logic                          rvalid,
   input  wire logic                     rready,
   input  wire logic                     write_clk,
   input  wire logic                     write_enable,
   input  wire logic [`TPBM_ADDR_W-1:0]  write_addr,
   input  wire logic [`TPBM_DATA_W-1:0]  write_data_in,
   input  wire logic                     read_clk,
   input  wire logic                     read_enable,
   input  wire logic [`TPBM_ADDR_W-1:0]  read_addr,
   output logic [`TPBM_DATA_W-1:0]       read_data_out
);

   tpbm_mem_if mem ();

   tpbm_store u_store
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .port    (mem.mem)
   );

   // Input synchronisers and clock level filters
   logic [`TPBM_SY_W-1:0]  sy1_ff, sy2_ff, sy3_ff;
   logic                   wlvl_ff, rlvl_ff;
   logic                   nxt_wlvl, nxt_rlvl;
   logic                   w_edge, r_edge;
   logic [31:0]            cfg_ff;

   always_comb
   begin
      nxt_wlvl = wlvl_ff;
      nxt_rlvl = rlvl_ff;
      w_edge   = 1'b0;
      r_edge   = 1'b0;
      if (sy2_ff[`TPBM_SY_WCLK] == sy3_ff[`TPBM_SY_WCLK])
      begin
         nxt_wlvl = sy3_ff[`TPBM_SY_WCLK];
         // Active edge is the level change into the selected sense
         w_edge   = (nxt_wlvl != wlvl_ff) &&
                    (nxt_wlvl != cfg_ff[`TPBM_CFG_WFALL]);
      end
      if (sy2_ff[`TPBM_SY_RCLK] == sy3_ff[`TPBM_SY_RCLK])
      begin
         nxt_rlvl = sy3_ff[`TPBM_SY_RCLK];
         r_edge   = (nxt_rlvl != rlvl_ff) &&
                    (nxt_rlvl != cfg_ff[`TPBM_CFG_RFALL]);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sy1_ff  <= '0;
         sy2_ff  <= '0;
         sy3_ff  <= '0;
         wlvl_ff <= 1'b0;
         rlvl_ff <= 1'b0;
      end
      else
      begin
         sy1_ff  <= {write_clk, read_clk, write_enable, read_enable,
                     write_addr, read_addr, write_data_in};
         sy2_ff  <= sy1_ff;
         sy3_ff  <= sy2_ff;
         wlvl_ff <= nxt_wlvl;
         rlvl_ff <= nxt_rlvl;
      end
   end

   // Port access control
   logic [`TPBM_ADDR_W-1:0]  s_wr_addr, s_rd_addr;
   logic [`TPBM_DATA_W-1:0]  s_wdata, rd_word;
   logic                     wen_act, ren_act, wsel_ok, rw_ok;
   logic                     wsel_wide, rw_wide, do_wr, do_rd;
   logic                     rd_pend_ff, rd_sel_ff, rd_wide_ff;
   logic [`TPBM_DATA_W-1:0]  stage_ff, out_ff;
   logic [`TPBM_CNT_W-1:0]   wcnt_ff, rcnt_ff;
   logic [`TPBM_DATA_W-1:0]  nxt_stage, nxt_out;
   logic [`TPBM_CNT_W-1:0]   nxt_wcnt, nxt_rcnt;

   always_comb
   begin
      s_wr_addr = sy3_ff[`TPBM_SY_WR_ADDR];
      s_rd_addr = sy3_ff[`TPBM_SY_RD_ADDR];
      s_wdata   = sy3_ff[`TPBM_SY_WDATA];
      wen_act = sy3_ff[`TPBM_SY_WEN] ~^ cfg_ff[`TPBM_CFG_WEN_HI];
      ren_act = sy3_ff[`TPBM_SY_REN] ~^ cfg_ff[`TPBM_CFG_REN_HI];
      wsel_wide = cfg_ff[`TPBM_CFG_WSEL] == `TPBM_WIDTH_18;
      rw_wide   = cfg_ff[`TPBM_CFG_RW] == `TPBM_WIDTH_18;
      // Reserved codes shut the port rather than guess a layout
      wsel_ok = wsel_wide || (cfg_ff[`TPBM_CFG_WSEL] == `TPBM_WIDTH_9);
      rw_ok   = rw_wide || (cfg_ff[`TPBM_CFG_RW] == `TPBM_WIDTH_9);
      do_wr   = w_edge && wen_act && wsel_ok;
      do_rd   = r_edge && ren_act && rw_ok;

      mem.we   = '0;
      mem.re   = do_rd;
      if (wsel_wide)
      begin
         // Address bit 8 is ignored; the driver keeps it low
         mem.wrow  = s_wr_addr[`TPBM_ROW_W-1:0];
         mem.wdata = s_wdata;
         mem.we    = {`TPBM_BANKS{do_wr}};
      end
      else
      begin
         // Bits 17:9 are dropped in narrow mode
         mem.wrow  = s_wr_addr[`TPBM_ADDR_W-1:1];
         mem.wdata = {2{s_wdata[`TPBM_HALF_W-1:0]}};
         mem.we[s_wr_addr[0]] = do_wr;
      end
      mem.rrow = rw_wide ? s_rd_addr[`TPBM_ROW_W-1:0]
                         : s_rd_addr[`TPBM_ADDR_W-1:1];

      if (rd_wide_ff)
         rd_word = mem.rdata;
      else
         // Upper half is driven zero; users must not rely on it
         rd_word = {{`TPBM_HALF_W{1'b0}},
                    rd_sel_ff ? mem.rdata[`TPBM_DATA_W-1:`TPBM_HALF_W]
                              : mem.rdata[`TPBM_HALF_W-1:0]};

      nxt_stage = stage_ff;
      nxt_out   = out_ff;
      if (cfg_ff[`TPBM_CFG_PIPE])
      begin
         // Extra register shows data at the next active read edge
         if (rd_pend_ff)
            nxt_stage = rd_word;
         if (r_edge)
            nxt_out = stage_ff;
      end
      else if (rd_pend_ff)
         nxt_out = rd_word;
      nxt_wcnt = do_wr ? wcnt_ff + 1'b1 : wcnt_ff;
      nxt_rcnt = do_rd ? rcnt_ff + 1'b1 : rcnt_ff;
   end

   // Reset clears hold registers; strobes are not gated by reset, they only drop once the synchronisers clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_pend_ff <= 1'b0;
         rd_sel_ff  <= 1'b0;
         rd_wide_ff <= 1'b0;
         stage_ff   <= '0;
         out_ff     <= '0;
         wcnt_ff    <= '0;
         rcnt_ff    <= '0;
      end
      else
      begin
         rd_pend_ff <= do_rd;
         rd_sel_ff  <= do_rd ? s_rd_addr[0] : rd_sel_ff;
         rd_wide_ff <= do_rd ? rw_wide : rd_wide_ff;
         stage_ff   <= nxt_stage;
         out_ff     <= nxt_out;
         wcnt_ff    <= nxt_wcnt;
         rcnt_ff    <= nxt_rcnt;
      end
   end

   assign read_data_out = out_ff;

   // AXI4-Lite slave
   tpbm_wr_state_t           wst_ff, nxt_wst;
   tpbm_rd_state_t           rst_ff, nxt_rst;
   logic                     aw_got_ff, w_got_ff, nxt_aw_got, nxt_w_got;
   logic [`TPBM_AXI_AW-1:0]  awaddr_ff, nxt_awaddr;
   logic [31:0]              wdata_ff, nxt_wdata, nxt_cfg, rdata_ff;
   logic [31:0]              nxt_rdata, stat;
   logic [3:0]               wstrb_ff, nxt_wstrb;
   logic [1:0]               bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic                     have_aw, have_w;
   logic [`TPBM_AXI_AW-1:0]  eff_addr;
   logic [31:0]              eff_data;
   logic [3:0]               eff_strb;

   always_comb
   begin
      stat = '0;
      stat[`TPBM_STAT_WSEL_BAD] = !wsel_ok;
      stat[`TPBM_STAT_RW_BAD] = !rw_ok;
      stat[`TPBM_STAT_WCNT]   = wcnt_ff;
      stat[`TPBM_STAT_RCNT]   = rcnt_ff;

      nxt_wst    = wst_ff;
      nxt_aw_got = aw_got_ff;
      nxt_w_got  = w_got_ff;
      nxt_awaddr = awaddr_ff;
      nxt_wdata  = wdata_ff;
      nxt_wstrb  = wstrb_ff;
      nxt_bresp  = bresp_ff;
      nxt_cfg    = cfg_ff;
      have_aw    = aw_got_ff || (awvalid && awready);
      have_w     = w_got_ff || (wvalid && wready);
      eff_addr   = aw_got_ff ? awaddr_ff : awaddr;
      eff_data   = w_got_ff ? wdata_ff : wdata;
      eff_strb   = w_got_ff ? wstrb_ff : wstrb;
      case (wst_ff)
         TPBM_WR_COLLECT:
         begin
            if (awvalid && awready)
            begin
               nxt_aw_got = 1'b1;
               nxt_awaddr = awaddr;
            end
            if (wvalid && wready)
            begin
               nxt_w_got = 1'b1;
               nxt_wdata = wdata;
               nxt_wstrb = wstrb;
            end
            if (have_aw && have_w)
            begin
               nxt_wst    = TPBM_WR_RESP;
               nxt_aw_got = 1'b0;
               nxt_w_got  = 1'b0;
               nxt_bresp  = `TPBM_RESP_OKAY;
               if (eff_addr == `TPBM_OFS_CFG)
               begin
                  for (int i = 0; i < 4; i++)
                     if (eff_strb[i])
                        nxt_cfg[i*8 +: 8] = eff_data[i*8 +: 8];
                  nxt_cfg = nxt_cfg & `TPBM_CFG_MASK;
               end
               else if (eff_addr != `TPBM_OFS_STAT)
                  nxt_bresp = `TPBM_RESP_SLVERR;
            end
         end
         TPBM_WR_RESP:
            if (bready)
               nxt_wst = TPBM_WR_COLLECT;
         default:
            nxt_wst = TPBM_WR_COLLECT;
      endcase

      nxt_rst   = rst_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      case (rst_ff)
         TPBM_RD_IDLE:
            if (arvalid && arready)
            begin
               nxt_rst   = TPBM_RD_RESP;
               nxt_rresp = `TPBM_RESP_OKAY;
               if (araddr == `TPBM_OFS_CFG)
                  nxt_rdata = cfg_ff;
               else if (araddr == `TPBM_OFS_STAT)
                  nxt_rdata = stat;
               else
               begin
                  nxt_rdata = '0;
                  nxt_rresp = `TPBM_RESP_SLVERR;
               end
            end
         TPBM_RD_RESP:
            if (rready)
               nxt_rst = TPBM_RD_IDLE;
         default:
            nxt_rst = TPBM_RD_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wst_ff    <= TPBM_WR_COLLECT;
         rst_ff    <= TPBM_RD_IDLE;
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff  <= '0;
         wstrb_ff  <= '0;
         bresp_ff  <= `TPBM_RESP_OKAY;
         rresp_ff  <= `TPBM_RESP_OKAY;
         rdata_ff  <= '0;
         cfg_ff    <= `TPBM_CFG_RST;
         awready   <= 1'b0;
         wready    <= 1'b0;
         bvalid    <= 1'b0;
         arready   <= 1'b0;
         rvalid    <= 1'b0;
      end
      else
      begin
         wst_ff    <= nxt_wst;
         rst_ff    <= nxt_rst;
         aw_got_ff <= nxt_aw_got;
         w_got_ff  <= nxt_w_got;
         awaddr_ff <= nxt_awaddr;
         wdata_ff  <= nxt_wdata;
         wstrb_ff  <= nxt_wstrb;
         bresp_ff  <= nxt_bresp;
         rresp_ff  <= nxt_rresp;
         rdata_ff  <= nxt_rdata;
         cfg_ff    <= nxt_cfg;
         // Readies are registered so every output comes from a flop
         awready   <= (nxt_wst == TPBM_WR_COLLECT) && !nxt_aw_got;
         wready    <= (nxt_wst == TPBM_WR_COLLECT) && !nxt_w_got;
         bvalid    <= nxt_wst == TPBM_WR_RESP;
         arready   <= nxt_rst == TPBM_RD_IDLE;
         rvalid    <= nxt_rst == TPBM_RD_RESP;
      end
   end

   assign bresp = bresp_ff;
   assign rresp = rresp_ff;
   assign rdata = rdata_ff;

endmodule : tpbm_two_port_ram

// *** tpbm_two_port_ram_assertions.sv ***
// Purpose: Port checks of the two-port block memory
// Assumes: Bound to the top module, sees its ports only
// Notes:   Read data may only move a few cycles after a read clock toggle
`timescale 1ns/10ps

module tpbm_two_port_ram_assertions (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [3:0]  araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        read_clk,
   input wire logic [17:0] read_data_out
);
   logic       rclk_ff, nxt_rclk;
   logic [7:0] age_ff, nxt_age;
   // Cycles since the read clock pin last toggled, saturating
   always_comb
   begin
      nxt_rclk = read_clk;
      nxt_age  = (age_ff == 8'hff) ? age_ff : age_ff + 8'h1;
      if (!aresetn)
         nxt_age = 8'hff;
      else if (read_clk != rclk_ff)
         nxt_age = 8'h0;
   end
   always_ff @(posedge aclk)
   begin
      rclk_ff <= nxt_rclk;
      age_ff  <= nxt_age;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Reset checks cannot be disabled by the reset they watch
   property p_rst_out;
      disable iff (1'b0) !aresetn |=> read_data_out == 18'h0;
   endproperty
   a_rst_out: assert property (p_rst_out)
      else $error("read data not cleared in reset");
   property p_rst_bus;
      disable iff (1'b0) !aresetn |=>
         !(awready || wready || arready || bvalid || rvalid);
   endproperty
   a_rst_bus: assert property (p_rst_bus)
      else $error("bus handshake active in reset");
   property p_rd_cause;
      $changed(read_data_out) && $past(aresetn) |->
         age_ff inside {[8'd3:8'd8]};
   endproperty
   a_rd_cause: assert property (p_rd_cause)
      else $error("read data moved without a read clock edge");
   property p_rd_ans;
      arvalid && arready |=> rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
   property p_wr_ans;
      awvalid && awready && wvalid && wready |=> bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
   property p_r_once;
      rvalid && rready |=> !rvalid;
   endproperty
   a_r_once: assert property (p_r_once) else $error("read answer kept");
   property p_b_once;
      bvalid && bready |=> !bvalid ##[0:1] (awready && wready);
   endproperty
   a_b_once: assert property (p_b_once) else $error("write not reopened");
   property p_unmapped;
      arvalid && arready && araddr[3] |=>
         rvalid && rresp == 2'h2 && rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("bad unmapped read");
endmodule : tpbm_two_port_ram_assertions

bind tpbm_two_port_ram tpbm_two_port_ram_assertions i_chk (.aclk, .aresetn,
   .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .araddr, .arvalid,
   .arready, .rdata, .rresp, .rvalid, .rready, .read_clk, .read_data_out);

// *** tpbm_fabric_model.sv ***
// Purpose: Fabric logic driving the memory write and read ports
// Assumes: Port clocks are slow, hold cycles per clock level
// Notes:   Call xfer for one clocked write or read
`timescale 1ns/10ps

module tpbm_fabric_model (
   input  wire logic   aclk,
   output logic        write_clk,
   output logic        write_enable,
   output logic [8:0]  write_addr,
   output logic [17:0] write_data_in,
   output logic        read_clk,
   output logic        read_enable,
   output logic [8:0]  read_addr
);
   int unsigned hold = 9;
   // Clocks idle low so a reset never lands near a port edge
   initial
   begin
      {write_clk, read_clk} = 2'h0;
      {write_enable, read_enable} = 2'h3;
      {write_addr, read_addr} = 18'h0;
      write_data_in = 18'h0;
   end
   task automatic xfer(input logic w, input logic wide, input logic [8:0] a,
                       input logic [17:0] d, input logic en);
      logic [8:0]  am;
      logic [17:0] dm;
      am = wide ? {1'b0, a[7:0]} : a;
      dm = wide ? d : {9'h0, d[8:0]};
      @(posedge aclk);
      write_addr    <= w ? am : write_addr;
      write_data_in <= w ? dm : write_data_in;
      write_enable  <= w ? en : write_enable;
      read_addr     <= w ? read_addr : am;
      read_enable   <= w ? read_enable : en;
      repeat (hold) @(posedge aclk);
      write_clk <= w;
      read_clk  <= !w;
      repeat (hold) @(posedge aclk);
      write_clk <= 1'b0;
      read_clk  <= 1'b0;
      repeat (hold) @(posedge aclk);
      // Released lines flip so a late sample shows as wrong data
      am = am ^ {!wide, 8'hff};
      dm = dm ^ {wide ? 9'h1ff : 9'h0, 9'h1ff};
      write_addr    <= w ? am : write_addr;
      write_data_in <= w ? dm : write_data_in;
      write_enable  <= w ? !en : write_enable;
      read_addr     <= w ? read_addr : am;
      read_enable   <= w ? read_enable : !en;
   endtask : xfer
endmodule : tpbm_fabric_model

// *** tpbm_two_port_ram_tb.sv ***
// Purpose: Self-checking bench of the two-port block memory
// Assumes: Fabric model drives the memory ports
// Notes:   Registers are reached over AXI4-Lite
`timescale 1ns/10ps

module tpbm_two_port_ram_tb;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready;
   logic        bvalid, bready, arvalid, arready, rvalid, rready;
   logic        write_clk, write_enable, read_clk, read_enable;
   logic [1:0]  bresp, rresp;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [8:0]  write_addr, read_addr;
   logic [17:0] write_data_in, read_data_out;
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          cyc_cnt = 0;

   tpbm_two_port_ram i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .write_clk,
      .write_enable, .write_addr, .write_data_in, .read_clk, .read_enable,
      .read_addr, .read_data_out);
   tpbm_fabric_model i_fab (.aclk, .write_clk, .write_enable, .write_addr,
      .write_data_in, .read_clk, .read_enable, .read_addr);

   initial
   begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 3000)
      begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic end_of_test;
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rwr(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] er);
      logic aw;
      logic w;
      {aw, w} = 2'h3;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      while (aw || w)
      begin
         @(posedge aclk);
         aw = aw && (awready !== 1'b1);
         w  = w && (wready !== 1'b1);
         awvalid <= aw;
         wvalid  <= w;
      end
      while (bvalid !== 1'b1)
         @(posedge aclk);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask : rwr
   task automatic rrd(input logic [3:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do
         @(posedge aclk);
      while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1)
         @(posedge aclk);
      rready <= 1'b0;
      chk(rdata & m, e);
      chk({30'h0, rresp}, {30'h0, er});
   endtask : rrd
   task automatic mr(input logic wide, input logic [8:0] a, input logic en,
                     input logic [17:0] e);
      i_fab.xfer(1'b0, wide, a, 18'h0, en);
      chk({14'h0, read_data_out & (wide ? 18'h3ffff : 18'h1ff)}, {14'h0, e});
   endtask : mr
   task automatic rst;
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
   endtask : rst

   initial
   begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wstrb} = 12'h00f;
      wdata = 32'h0;
      rst();
      chk({14'h0, read_data_out}, 32'h0);
      rrd(4'h0, 32'h5, ~32'h0, 2'h0);
      rrd(4'h8, 32'h0, ~32'h0, 2'h2);
      rwr(4'hc, 32'h0, 2'h2);
      rwr(4'h4, 32'hff, 2'h0);
      rrd(4'h4, 32'h0, ~32'h0, 2'h0);
      i_fab.xfer(1'b1, 1'b0, 9'h003, 18'h0a5, 1'b0);
      i_fab.xfer(1'b1, 1'b0, 9'h002, 18'h15a, 1'b0);
      i_fab.xfer(1'b1, 1'b0, 9'h003, 18'h1ff, 1'b1);
      mr(1'b0, 9'h003, 1'b0, 18'h0a5);
      mr(1'b0, 9'h002, 1'b1, 18'h0a5);
      rwr(4'h0, 32'h00a, 2'h0);
      mr(1'b1, 9'h001, 1'b0, 18'h14b5a);
      i_fab.xfer(1'b1, 1'b1, 9'h103, 18'h2abcd, 1'b0);
      mr(1'b1, 9'h003, 1'b0, 18'h2abcd);
      rwr(4'h0, 32'h0fa, 2'h0);
      i_fab.xfer(1'b1, 1'b1, 9'h004, 18'h12345, 1'b1);
      i_fab.xfer(1'b1, 1'b1, 9'h004, 18'h3ffff, 1'b0);
      mr(1'b1, 9'h004, 1'b1, 18'h12345);
      rwr(4'h0, 32'h10a, 2'h0);
      i_fab.hold = 12;
      i_fab.xfer(1'b0, 1'b1, 9'h003, 18'h0, 1'b0);
      mr(1'b1, 9'h004, 1'b0, 18'h2abcd);
      mr(1'b1, 9'h004, 1'b0, 18'h12345);
      rwr(4'h0, 32'h00c, 2'h0);
      rrd(4'h4, 32'h0007_0403, ~32'h0, 2'h0);
      i_fab.xfer(1'b1, 1'b1, 9'h004, 18'h0, 1'b0);
      mr(1'b1, 9'h003, 1'b0, 18'h12345);
      rwr(4'h0, 32'h00a, 2'h0);
      mr(1'b1, 9'h004, 1'b0, 18'h12345);
      rst();
      chk({14'h0, read_data_out}, 32'h0);
      rrd(4'h0, 32'h5, ~32'h0, 2'h0);
      mr(1'b0, 9'h006, 1'b0, 18'h1cd);
      mr(1'b0, 9'h007, 1'b0, 18'h155);
      end_of_test();
   end
endmodule : tpbm_two_port_ram_tb
